// File: verilog/hemb_top.sv
// host / controller mailbox with host window into controller memory
// What this block does
// - thirteen host byte registers, controller registers separate
// - event pin low on mailbox or software event
// - software event from enabled software irq bits
// - controller mailbox write also raises software event
// - controller mailbox write raises host irq source
// - host mailbox write pulses controller irq
// - system reset clears every register
// - host and controller accesses on bus clock
// - idle when no transaction targets block
// - host reads interrupt source register
// - mask register blocks each event individually
// - sixteen bit address, thirty-two bit data
// - two controller memory regions exposed to host
// - host byte access, memory multi-byte transfers
// - data read fetches 1, 2, 4 bytes
// - data write commits selected bytes to memory
// - auto-increment steps through consecutive 32-bit words
// - base and limits controller side only
// - read and write limits independent
// - zero read limit makes region write-only
// - each window up to 32k bytes
// - regions read-only, write-only or read/write
// - width codes 00, 01, 10, 11
// - byte mode reads and writes single byte
// - 32-bit mode commits only on byte 3
// - writes outside write region leave memory
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module hemb_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // host byte bus
  input  wire logic        host_sel,
  input  wire logic        host_wr,
  input  wire logic [3:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic             host_ready,
  output logic [7:0]       host_rdata,
  // controller APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // controller memory master
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [3:0]       mem_be,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  // events
  output logic             host_event_n_out,
  output logic             ctrl_irq_out,
  output logic             low_power_out
);
  import hemb_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {HEMB_IDLE, HEMB_MEMRD, HEMB_DONE} hemb_state_e;

  hemb_state_e  state_q;
  logic [7:0]   h2c_mbox_q;
  logic [7:0]   c2h_mbox_q;
  logic [15:0]  window_address;
  logic [31:0]  data_q;
  logic         c2h_event_q;
  logic [15:1]  ctrl_software_irq_bits;
  logic [15:0]  mask_q;
  logic [7:0]   app_id_q;
  logic [31:0]  base_q [2];
  logic [LIM_W-1:0] rlim_q [2];
  logic [LIM_W-1:0] wlim_q [2];
  logic [7:0]   rdata_q;
  logic [3:0]   fetch_be_q;
  logic [1:0]   fetch_lane_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic         h_take;
  logic         h_wr_take;
  logic         h_data;
  logic [1:0]   lane;
  hemb_width_e  width;
  logic         region;
  logic [14:0]  offset;
  logic         can_read;
  logic         can_write;
  logic [3:0]   rd_be;
  logic [3:0]   wr_be;
  logic         need_fetch;
  logic         do_commit;
  logic         do_inc;
  logic [31:0]  lane_mask;
  logic [31:0]  data_wr;
  logic         c_wr;
  logic         c_rd;
  logic         c2h_set;
  logic [15:1]  swi_set;
  logic         host_software_event;
  logic [15:1]  ctrl_software_irq_enables;

  // host access taken in the idle state on the bus clock
  assign h_take    = host_sel && (state_q == HEMB_IDLE);
  assign h_wr_take = h_take && host_wr;
  assign h_data    = host_addr[3:2] == HOFF_DATA0[3:2];
  assign lane      = host_addr[1:0];
  assign width     = hemb_width_e'(window_address[1:0]);
  // top address bit picks one of two regions
  assign region    = window_address[ADDR_REGION_BIT];
  // fifteen-bit byte offset gives a 32k window
  assign offset    = {window_address[14:2], 2'b00};
  // read and write limits compared separately
  // a zero read limit never allows a host read
  // limits set read-only, write-only or read/write
  assign can_read  = offset < rlim_q[region];
  assign can_write = offset < wlim_q[region];

  always_comb begin
    rd_be = 4'h0;
    wr_be = 4'h0;
    unique case (width)
      // byte mode moves the addressed byte only
      HEMB_W8: begin
        rd_be = 4'h1 << lane;
        wr_be = 4'h1 << lane;
      end
      HEMB_W16: begin
        if (lane == 2'd0) rd_be = 4'h3;
        if (lane == 2'd2) rd_be = 4'hc;
        if (lane == 2'd1) wr_be = 4'h3;
        if (lane == 2'd3) wr_be = 4'hc;
      end
      // 32-bit mode commits on byte 3 only
      HEMB_W32, HEMB_W32INC: begin
        if (lane == 2'd0) rd_be = 4'hf;
        if (lane == 2'd3) wr_be = 4'hf;
      end
    endcase
  end

  // a read fetches the selected bytes when readable
  assign need_fetch = h_take && !host_wr && h_data && (rd_be != 4'h0) && can_read;
  // no memory write outside the write region
  assign do_commit  = h_wr_take && h_data && (wr_be != 4'h0) && can_write;
  // in auto-increment mode byte 3 steps the address; writes out of bounds do not
  assign do_inc     = h_take && h_data && (lane == 2'd3) && (width == HEMB_W32INC)
                      && (!host_wr || can_write);

  always_comb begin
    lane_mask = {{8{fetch_be_q[3]}}, {8{fetch_be_q[2]}}, {8{fetch_be_q[1]}}, {8{fetch_be_q[0]}}};
    data_wr   = data_q;
    data_wr[lane*8 +: 8] = host_wdata;
  end

  // ---------------------------------------------------------------
  // host access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= HEMB_IDLE;
    end else begin
      unique case (state_q)
        HEMB_IDLE:  if (host_sel) state_q <= need_fetch ? HEMB_MEMRD : HEMB_DONE;
        HEMB_MEMRD: if (mem_rvalid) state_q <= HEMB_DONE;
        HEMB_DONE:  state_q <= HEMB_IDLE;
        default:    state_q <= HEMB_IDLE;
      endcase
    end
  end

  assign host_ready = state_q == HEMB_DONE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fetch_be_q   <= 4'h0;
      fetch_lane_q <= 2'd0;
    end else if (need_fetch) begin
      fetch_be_q   <= rd_be;
      fetch_lane_q <= lane;
    end
  end

  // memory request carries one, two or four bytes per host byte access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= RST_WORD;
      mem_be    <= 4'h0;
      mem_wdata <= RST_WORD;
    end else begin
      mem_req <= 1'b0;
      if (need_fetch || do_commit) begin
        mem_req   <= 1'b1;
        mem_we    <= host_wr;
        mem_addr  <= base_q[region] + {17'h00000, offset};
        mem_be    <= host_wr ? wr_be : rd_be;
        // selected data bytes including the new byte
        mem_wdata <= data_wr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_q <= RST_WORD;
    end else if (state_q == HEMB_MEMRD && mem_rvalid) begin
      data_q <= (data_q & ~lane_mask) | (mem_rdata & lane_mask);
    end else if (h_wr_take && h_data) begin
      data_q <= data_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      window_address <= RST_HALF;
    end else if (h_wr_take && host_addr == HOFF_ADDR_LSB) begin
      window_address[7:0] <= host_wdata;
    end else if (h_wr_take && host_addr == HOFF_ADDR_MSB) begin
      window_address[15:8] <= host_wdata;
    end else if (do_inc) begin
      window_address[14:2] <= window_address[14:2] + 13'd1;
    end
  end

  // ---------------------------------------------------------------
  // host read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= RST_BYTE;
    end else if (state_q == HEMB_MEMRD && mem_rvalid) begin
      rdata_q <= mem_rdata[fetch_lane_q*8 +: 8];
    end else if (h_take && !host_wr) begin
      unique case (host_addr)
        HOFF_H2C_MBOX: rdata_q <= h2c_mbox_q;
        HOFF_C2H_MBOX: rdata_q <= c2h_mbox_q;
        HOFF_ADDR_LSB: rdata_q <= window_address[7:0];
        HOFF_ADDR_MSB: rdata_q <= window_address[15:8];
        4'h4, 4'h5, 4'h6, HOFF_DATA3: rdata_q <= data_q[lane*8 +: 8];
        HOFF_SRC_LSB:  rdata_q <= {ctrl_software_irq_bits[7:1], c2h_event_q};
        HOFF_SRC_MSB:  rdata_q <= ctrl_software_irq_bits[15:8];
        HOFF_MASK_LSB: rdata_q <= mask_q[7:0];
        HOFF_MASK_MSB: rdata_q <= mask_q[15:8];
        HOFF_APP_ID:   rdata_q <= app_id_q;
        default:       rdata_q <= RST_BYTE;
      endcase
    end
  end

  assign host_rdata = rdata_q;

  // ---------------------------------------------------------------
  // host writable registers
  // ---------------------------------------------------------------
  // host register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      h2c_mbox_q <= RST_BYTE;
      mask_q     <= RST_MASK;
      app_id_q   <= RST_BYTE;
    end else if (h_wr_take) begin
      if (host_addr == HOFF_H2C_MBOX) h2c_mbox_q <= host_wdata;
      if (host_addr == HOFF_MASK_LSB) mask_q[7:0] <= host_wdata;
      if (host_addr == HOFF_MASK_MSB) mask_q[15:8] <= host_wdata;
      if (host_addr == HOFF_APP_ID) app_id_q <= host_wdata;
    end
  end

  // pulse toward the controller interrupt aggregator
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_irq_out <= 1'b0;
    end else begin
      ctrl_irq_out <= h_wr_take && host_addr == HOFF_H2C_MBOX;
    end
  end

  // ---------------------------------------------------------------
  // controller APB slave
  // ---------------------------------------------------------------
  assign c_wr    = psel && penable && pwrite;
  assign c_rd    = psel && penable && !pwrite;
  assign c2h_set = c_wr && paddr == COFF_C2H_MBOX;
  assign swi_set = (c_wr && paddr == COFF_SWI) ? pwdata[15:1] : 15'h0000;
  assign pready  = 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c2h_mbox_q <= RST_BYTE;
    end else if (c2h_set) begin
      c2h_mbox_q <= pwdata[7:0];
    end
  end

  // base and limits written only through APB
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        base_q[i] <= RST_WORD;
        rlim_q[i] <= RST_HALF[LIM_W-1:0];
        wlim_q[i] <= RST_HALF[LIM_W-1:0];
      end
    end else if (c_wr) begin
      if (paddr == COFF_R0_BASE) base_q[0] <= pwdata;
      if (paddr == COFF_R1_BASE) base_q[1] <= pwdata;
      if (paddr == COFF_R0_LIMIT) begin
        rlim_q[0] <= pwdata[LIM_READ_LSB +: LIM_W];
        wlim_q[0] <= pwdata[LIM_WRITE_LSB +: LIM_W];
      end
      if (paddr == COFF_R1_LIMIT) begin
        rlim_q[1] <= pwdata[LIM_READ_LSB +: LIM_W];
        wlim_q[1] <= pwdata[LIM_WRITE_LSB +: LIM_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= RST_WORD;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      unique case (paddr)
        COFF_H2C_MBOX: prdata <= {24'h000000, h2c_mbox_q};
        COFF_C2H_MBOX: prdata <= {24'h000000, c2h_mbox_q};
        COFF_SWI:      prdata <= {16'h0000, ctrl_software_irq_bits, c2h_event_q};
        COFF_R0_BASE:  prdata <= base_q[0];
        COFF_R0_LIMIT: prdata <= {1'b0, wlim_q[0], 1'b0, rlim_q[0]};
        COFF_R1_BASE:  prdata <= base_q[1];
        COFF_R1_LIMIT: prdata <= {1'b0, wlim_q[1], 1'b0, rlim_q[1]};
        COFF_STATUS:   prdata <= {mask_q, window_address};
        default: begin
          prdata  <= RST_WORD;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event sources, set wins over host clear
  // ---------------------------------------------------------------
  // controller mailbox write raises the host source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c2h_event_q <= 1'b0;
    end else if (c2h_set) begin
      c2h_event_q <= 1'b1;
    end else if (h_wr_take && host_addr == HOFF_SRC_LSB && host_wdata[SRC_C2H_BIT]) begin
      c2h_event_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_software_irq_bits <= 15'h0000;
    end else begin
      if (h_wr_take && host_addr == HOFF_SRC_LSB) begin
        ctrl_software_irq_bits <= (ctrl_software_irq_bits & ~{8'h00, host_wdata[7:1]}) | swi_set;
      end else if (h_wr_take && host_addr == HOFF_SRC_MSB) begin
        ctrl_software_irq_bits <= (ctrl_software_irq_bits & ~{host_wdata, 7'h00}) | swi_set;
      end else begin
        ctrl_software_irq_bits <= ctrl_software_irq_bits | swi_set;
      end
    end
  end

  // a set mask bit blocks its event
  assign ctrl_software_irq_enables = ~mask_q[15:1];
  // enabled software bits raise the software event
  // unmasked mailbox event also raises it
  assign host_software_event = (|(ctrl_software_irq_bits & ctrl_software_irq_enables))
                               || (c2h_event_q && !mask_q[SRC_C2H_BIT]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_event_n_out <= 1'b1;
    end else begin
      host_event_n_out <= !((c2h_event_q && !mask_q[SRC_C2H_BIT]) || host_software_event);
    end
  end

  // low power flag whenever nothing targets the block
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= !host_sel && !psel && state_q == HEMB_IDLE;
    end
  end

  // every flop above clears on the synchronous reset except host_event_n_out, which resets high

endmodule : hemb_top

// File: common/hemb_pkg.sv
// shared constants for the host / controller mailbox and memory window block
package hemb_pkg;

  // ---------------------------------------------------------------
  // host byte register offsets (13 registers)
  // ---------------------------------------------------------------
  localparam logic [3:0] HOFF_H2C_MBOX  = 4'h0;
  localparam logic [3:0] HOFF_C2H_MBOX  = 4'h1;
  localparam logic [3:0] HOFF_ADDR_LSB  = 4'h2;
  localparam logic [3:0] HOFF_ADDR_MSB  = 4'h3;
  localparam logic [3:0] HOFF_DATA0     = 4'h4;
  localparam logic [3:0] HOFF_DATA3     = 4'h7;
  localparam logic [3:0] HOFF_SRC_LSB   = 4'h8;
  localparam logic [3:0] HOFF_SRC_MSB   = 4'h9;
  localparam logic [3:0] HOFF_MASK_LSB  = 4'ha;
  localparam logic [3:0] HOFF_MASK_MSB  = 4'hb;
  localparam logic [3:0] HOFF_APP_ID    = 4'hc;

  // ---------------------------------------------------------------
  // controller APB register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] COFF_H2C_MBOX  = 8'h00;
  localparam logic [7:0] COFF_C2H_MBOX  = 8'h04;
  localparam logic [7:0] COFF_SWI       = 8'h08;
  localparam logic [7:0] COFF_R0_BASE   = 8'h0c;
  localparam logic [7:0] COFF_R0_LIMIT  = 8'h10;
  localparam logic [7:0] COFF_R1_BASE   = 8'h14;
  localparam logic [7:0] COFF_R1_LIMIT  = 8'h18;
  localparam logic [7:0] COFF_STATUS    = 8'h1c;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int ADDR_REGION_BIT   = 15;
  localparam int LIM_READ_LSB      = 0;
  localparam int LIM_WRITE_LSB     = 16;
  localparam int LIM_W             = 15;
  localparam int SRC_C2H_BIT       = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_HALF   = 16'h0000;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [15:0] RST_MASK   = 16'h0000;

  // transfer width codes
  typedef enum logic [1:0] {
    HEMB_W8     = 2'b00,
    HEMB_W16    = 2'b01,
    HEMB_W32    = 2'b10,
    HEMB_W32INC = 2'b11
  } hemb_width_e;

endpackage : hemb_pkg

// File: testbench/hemb_mem_model.sv
// behavioural controller memory answering the window requests
`timescale 1ns/1ps
module hemb_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [0:4095];
  logic [31:0] last_q;
  logic [11:0] ridx_q;
  int          wait_q;
  initial begin
    mem_rvalid = 1'b0;
    mem_rdata  = 32'h0;
    last_q     = 32'h0;
    wait_q     = 0;
  end
  // ----------------------------------------
  // one word per request, delay of 1 or 4
  // ----------------------------------------
  always @(posedge clk) begin
    mem_rvalid <= 1'b0;
    // stale read data shows inverted
    mem_rdata  <= ~last_q;
    if (mem_req && mem_we) begin
      for (int b = 0; b < 4; b++) begin
        if (mem_be[b]) mem[mem_addr[13:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
      end
    end
    if (mem_req && !mem_we) begin
      ridx_q <= mem_addr[13:2];
      wait_q <= slow ? 4 : 1;
    end else if (wait_q == 1) begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= mem[ridx_q];
      last_q     <= mem[ridx_q];
      wait_q     <= 0;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule : hemb_mem_model

// File: testbench/hemb_assertions.sv
// port assertions for the mailbox and memory window block
`timescale 1ns/1ps
module hemb_assertions (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       host_sel,
  input wire logic       host_wr,
  input wire logic [3:0] host_addr,
  input wire logic       host_ready,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       mem_req,
  input wire logic       mem_we,
  input wire logic       ctrl_irq_out,
  input wire logic       low_power_out
);
  import hemb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence mbox_wr_s;
    host_sel && host_wr && host_addr == HOFF_H2C_MBOX && host_ready;
  endsequence
  sequence apb_acc_s;
    psel && penable;
  endsequence
  apb_ready_a: assert property (apb_acc_s |-> pready)
    else $error("apb access stalled");
  host_answer_a: assert property ($rose(host_sel) |-> ##[1:40] host_ready)
    else $error("host access never answered");
  ready_pulse_a: assert property (host_ready |=> !host_ready)
    else $error("host ready longer than a cycle");
  irq_raise_a: assert property (mbox_wr_s |-> ##[0:2] ctrl_irq_out)
    else $error("mailbox write gave no controller irq");
  irq_pulse_a: assert property (ctrl_irq_out |=> !ctrl_irq_out)
    else $error("controller irq not a pulse");
  unmapped_err_a: assert property (apb_acc_s |-> pslverr == (paddr > COFF_STATUS || paddr[1:0] != 2'b00))
    else $error("apb error flag wrong");
  fetch_cause_a: assert property (mem_req && !mem_we |-> host_sel && !host_wr)
    else $error("memory read without host read");
  commit_cause_a: assert property (mem_req && mem_we |-> host_sel && host_wr)
    else $error("memory write without host write");
  busy_wake_a: assert property (psel |=> !low_power_out)
    else $error("low power during apb access");
  idle_sleep_a: assert property ((!host_sel && !psel) [*3] |-> low_power_out)
    else $error("idle block not in low power");
endmodule : hemb_assertions
bind hemb_top hemb_assertions hemb_assertions_i (
  .clk(clk), .rst_n(rst_n), .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr),
  .host_ready(host_ready), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .ctrl_irq_out(ctrl_irq_out),
  .low_power_out(low_power_out)
);

// File: testbench/tb_top.sv
// self-checking bench for the mailbox and memory window block
`timescale 1ns/1ps
module tb_top;
  import hemb_pkg::*;
  logic        clk, rst_n, host_sel, host_wr, host_ready, psel, penable, pwrite, pready, pslverr, perr;
  logic        mem_req, mem_we, mem_rvalid, host_event_n_out, ctrl_irq_out, low_power_out, slow;
  logic [3:0]  host_addr, mem_be;
  logic [7:0]  host_wdata, host_rdata, paddr, hb;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, pw;
  int          err_total, checks, irq_cnt, fetch_cnt, f0;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  hemb_top hemb_top_i (
    .clk(clk), .rst_n(rst_n), .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_ready(host_ready), .host_rdata(host_rdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .host_event_n_out(host_event_n_out), .ctrl_irq_out(ctrl_irq_out), .low_power_out(low_power_out)
  );
  hemb_mem_model hemb_mem_model_i (
    .clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
  );
  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic hx(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    host_sel   <= 1'b1;
    host_wr    <= wr;
    host_addr  <= a;
    host_wdata <= d;
    // ready and read byte taken at the rising edge that sees ready high
    do begin
      @(posedge clk);
    end while (host_ready !== 1'b1);
    hb = host_rdata;
    host_sel <= 1'b0;
    @(negedge clk);
  endtask : hx
  task automatic ax(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    pw      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask : ax
  task automatic pin(input logic e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("event pin", e, host_event_n_out);
  endtask : pin
  task automatic final_report;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    if (ctrl_irq_out === 1'b1) irq_cnt++;
    if (mem_req === 1'b1 && mem_we === 1'b0) fetch_cnt++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {host_sel, host_wr, host_addr, host_wdata, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    rst_n     = 1'b0;
    err_total = 0;
    checks    = 0;
    irq_cnt   = 0;
    fetch_cnt = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    ax(0, COFF_C2H_MBOX, 0);
    chk("c2h reset", 0, pw);
    chk("pin reset", 1, host_event_n_out);
    ax(0, 8'h20, 0);
    chk("unmapped", 1, perr);
    hx(1, HOFF_H2C_MBOX, 8'h5a);
    repeat (3) @(posedge clk);
    chk("ctrl irq", 1, irq_cnt);
    ax(0, COFF_H2C_MBOX, 0);
    chk("h2c mbox", 32'h5a, pw);
    hx(1, HOFF_APP_ID, 8'h3c);
    hx(0, HOFF_APP_ID, 0);
    chk("app id", 8'h3c, hb);
    ax(1, COFF_C2H_MBOX, 32'ha5);
    pin(0);
    hx(0, HOFF_C2H_MBOX, 0);
    chk("c2h host", 8'ha5, hb);
    hx(0, HOFF_SRC_LSB, 0);
    chk("src c2h", 1, hb & 8'h01);
    hx(1, HOFF_SRC_LSB, 8'hff);
    hx(1, HOFF_SRC_MSB, 8'hff);
    pin(1);
    ax(1, COFF_SWI, 32'h2);
    pin(0);
    hx(0, HOFF_SRC_LSB, 0);
    chk("src swi", 8'h02, hb & 8'h02);
    hx(1, HOFF_MASK_LSB, 8'h02);
    pin(1);
    hx(1, HOFF_MASK_LSB, 8'h00);
    pin(0);
    hx(1, HOFF_SRC_LSB, 8'h02);
    pin(1);
    hemb_mem_model_i.mem[12'h400] = 32'h44332211;
    hemb_mem_model_i.mem[12'h401] = 32'hdeadbeef;
    hemb_mem_model_i.mem[12'h404] = 32'h88776655;
    hemb_mem_model_i.mem[12'h800] = 32'h0;
    ax(1, COFF_R0_BASE, 32'h1000);
    ax(1, COFF_R0_LIMIT, 32'h0010_0020);
    ax(1, COFF_R1_BASE, 32'h2000);
    ax(1, COFF_R1_LIMIT, 32'h0010_0000);
    hx(1, HOFF_ADDR_MSB, 8'h00);
    hx(1, HOFF_ADDR_LSB, {6'd0, HEMB_W32});
    f0 = fetch_cnt;
    hx(0, HOFF_DATA0, 0);
    chk("word read", 8'h11, hb);
    hx(0, 4'h5, 0);
    chk("reg byte", 8'h22, hb);
    chk("one fetch", f0 + 1, fetch_cnt);
    slow <= 1'b1;
    hx(1, HOFF_ADDR_LSB, {6'd0, HEMB_W8});
    hx(1, 4'h5, 8'hee);
    chk("byte commit", 32'h4433ee11, hemb_mem_model_i.mem[12'h400]);
    hx(0, 4'h6, 0);
    chk("byte read", 8'h33, hb);
    slow <= 1'b0;
    hx(1, HOFF_ADDR_LSB, {6'd1, HEMB_W32INC});
    for (int i = 0; i < 3; i++) hx(1, 4'(4 + i), 8'(i + 1));
    chk("no early commit", 32'hdeadbeef, hemb_mem_model_i.mem[12'h401]);
    hx(1, HOFF_DATA3, 8'h04);
    chk("word commit", 32'h04030201, hemb_mem_model_i.mem[12'h401]);
    hx(0, HOFF_ADDR_LSB, 0);
    chk("auto inc", {6'd2, HEMB_W32INC}, hb);
    hx(1, HOFF_ADDR_LSB, {6'd0, HEMB_W16});
    hx(0, 4'h6, 0);
    chk("half read", 8'h33, hb);
    hx(0, HOFF_DATA3, 0);
    chk("half upper", 8'h44, hb);
    hx(1, HOFF_DATA0, 8'h66);
    hx(1, 4'h5, 8'h77);
    chk("half commit", 32'h44337766, hemb_mem_model_i.mem[12'h400]);
    hx(1, HOFF_ADDR_LSB, {6'd4, HEMB_W32});
    hx(1, HOFF_DATA3, 8'haa);
    chk("ro kept", 32'h88776655, hemb_mem_model_i.mem[12'h404]);
    hx(0, HOFF_DATA0, 0);
    chk("ro read", 8'h55, hb);
    hx(1, HOFF_ADDR_MSB, 8'h80);
    hx(1, HOFF_ADDR_LSB, {6'd0, HEMB_W32});
    for (int i = 0; i < 4; i++) hx(1, 4'(4 + i), 8'(17 * (i + 1)));
    chk("wo commit", 32'h44332211, hemb_mem_model_i.mem[12'h800]);
    f0 = fetch_cnt;
    hx(0, HOFF_DATA0, 0);
    chk("wo read", 8'h11, hb);
    chk("wo no fetch", f0, fetch_cnt);
    ax(1, COFF_C2H_MBOX, 32'h1);
    pin(0);
    ax(0, COFF_STATUS, 0);
    chk("status", 32'h0000_8002, pw);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    ax(0, COFF_H2C_MBOX, 0);
    chk("mbox reset", 0, pw);
    ax(0, COFF_R0_BASE, 0);
    chk("base reset", 0, pw);
    chk("pin reset", 1, host_event_n_out);
    final_report;
  end
endmodule : tb_top
